/* File: design/interval_timer_compare.v */
// Interval timer with two compare channels and a wrap flag.
// Assumes control and compare values come as plain ports, writes are
// one-cycle strobes, and all count clocks are slow compared to clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
`include "interval_timer_map.vh"

module interval_timer_compare
#(
    parameter W = 16
)
(
    input  wire         clk_sys_i,                // System clock, 50 MHz
    input  wire         rst_n_i,                  // Power-on reset, active low
    input  wire         external_count_clock_i,   // External timer clock
    input  wire         aux_clock_i,              // Auxiliary clock
    input  wire         subsystem_clock_i,        // Subsystem clock
    input  wire         ctl_wr_i,                 // Full control word write strobe
    input  wire [W-1:0] ctl_wdata_i,              // Control word write data
    input  wire         period_wr_i,              // Period compare write strobe
    input  wire [W-1:0] period_wdata_i,           // Period compare data
    input  wire         ch1_wr_i,                 // Channel 1 compare write strobe
    input  wire [W-1:0] ch1_wdata_i,              // Channel 1 compare data
    input  wire         ch1_cmp_mode_i,           // Channel 1 in compare mode
    input  wire         ch2_wr_i,                 // Channel 2 compare write strobe
    input  wire [W-1:0] ch2_wdata_i,              // Channel 2 compare data
    input  wire         ch2_cmp_mode_i,           // Channel 2 in compare mode
    input  wire         flag_clr_i,               // Clear all flags strobe
    output reg  [W-1:0] running_count_o,          // Running count
    output reg  [W-1:0] timer_control_word_o,     // Control word readback
    output reg  [3:0]   timer_vector_word_o,      // Highest pending source
    output reg          wrap_flag_o,              // Sticky wrap flag
    output reg          ch1_flag_o,               // Sticky channel 1 flag
    output reg          ch2_flag_o                // Sticky channel 2 flag
);

    reg  [W-1:0] period_compare_value_q;
    reg  [W-1:0] ch1_compare_value_q;
    reg  [W-1:0] ch2_compare_value_q;
    reg  [2:0]   div_cnt_q;
    reg  [W-1:0] count_d;
    reg          src_level;
    reg          step;
    reg          wrap_ev;
    wire         src_rise;
    wire [1:0]   src_sel = timer_control_word_o[`CTL_SRC_LSB+1:`CTL_SRC_LSB];
    wire [1:0]   input_divider_field = timer_control_word_o[`CTL_DIV_LSB+1:`CTL_DIV_LSB];
    wire [1:0]   mode = timer_control_word_o[`CTL_MODE_LSB+1:`CTL_MODE_LSB];
    wire         count_clear_bit = ctl_wr_i & ctl_wdata_i[`CTL_CLR_BIT];
    wire         ch1_hit;
    wire         ch2_hit;

    // Divider terminal value for a divider code
    function [2:0] div_last;
        input [1:0] code;
        begin
            case (code)
                `DIV_1:  div_last = 3'h0;
                `DIV_2:  div_last = 3'h1;
                `DIV_4:  div_last = 3'h3;
                default: div_last = 3'h7;
            endcase
        end
    endfunction

    // ****************************************************************
    // Source selection and synchronisation
    // ****************************************************************

    always @*
    begin
        case (src_sel)
            `SRC_EXT_CLK:     src_level = external_count_clock_i;
            `SRC_AUX_CLK:     src_level = aux_clock_i;
            `SRC_SUB_CLK:     src_level = subsystem_clock_i;
            `SRC_INV_EXT_CLK: src_level = ~external_count_clock_i;
            default:          src_level = 1'b0;
        endcase
    end

    // Edges cross into the system clock domain
    count_edge_sync i_count_edge_sync
    (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .level_i   (src_level),
        .rise_o    (src_rise)
    );

    // ****************************************************************
    // Divider and count step
    // ****************************************************************

    // Step only at divider terminal, even right after a clear
    // A step that meets a clear is dropped, so no flag claims a lost count
    always @*
    begin
        step = src_rise && (mode != `MODE_STOP) && !count_clear_bit
               && (div_cnt_q == div_last(input_divider_field));
    end

    // Next count value; wrap when leaving the period value in up mode, or on rollover to zero in continuous mode
    always @*
    begin
        count_d = running_count_o;
        wrap_ev = 1'b0;
        if (step)
        begin
            case (mode)
                `MODE_UP:
                begin
                    // Wrap only on period to zero
                    if (running_count_o == period_compare_value_q)
                    begin
                        count_d = `COUNT_ZERO;
                        wrap_ev = 1'b1;
                    end
                    else
                    begin
                        count_d = running_count_o + `COUNT_ONE;
                    end
                end
                `MODE_CONT:
                begin
                    count_d = running_count_o + `COUNT_ONE;
                    wrap_ev = (count_d == `COUNT_ZERO);
                end
                default:
                begin
                    count_d = running_count_o + `COUNT_ONE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Compare detection
    // ****************************************************************

    // Match checked on each count step against live values, so
    // a compare moved forward by one still matches the next increment
    assign ch1_hit = ch1_cmp_mode_i && step && (count_d == ch1_compare_value_q);
    assign ch2_hit = ch2_cmp_mode_i && step && (count_d == ch2_compare_value_q);

    // ****************************************************************
    // Registers
    // ****************************************************************

    // Count, divider and control state
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            running_count_o        <= `COUNT_ZERO;
            div_cnt_q              <= `DIV_CNT_ZERO;
            timer_control_word_o   <= `CTL_RESET_VAL;
            period_compare_value_q <= `COUNT_ZERO;
            ch1_compare_value_q    <= `COUNT_ZERO;
            ch2_compare_value_q    <= `COUNT_ZERO;
        end
        else
        begin
            // Control only changes on its own write, never on compare updates
            if (ctl_wr_i)
            begin
                timer_control_word_o <= ctl_wdata_i & ~(16'h0001 << `CTL_CLR_BIT);
            end
            if (period_wr_i)
            begin
                period_compare_value_q <= period_wdata_i;
            end
            if (ch1_wr_i)
            begin
                ch1_compare_value_q <= ch1_wdata_i;
            end
            if (ch2_wr_i)
            begin
                ch2_compare_value_q <= ch2_wdata_i;
            end
            // Clear bit zeroes count and restarts divider
            if (count_clear_bit)
            begin
                running_count_o <= `COUNT_ZERO;
                div_cnt_q       <= `DIV_CNT_ZERO;
            end
            else if (src_rise && mode != `MODE_STOP)
            begin
                running_count_o <= count_d;
                div_cnt_q       <= step ? `DIV_CNT_ZERO : div_cnt_q + 3'h1;
            end
        end
    end

    // Sticky flags; a new event beats a same-cycle clear
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            wrap_flag_o <= 1'b0;
            ch1_flag_o  <= 1'b0;
            ch2_flag_o  <= 1'b0;
        end
        else
        begin
            wrap_flag_o <= wrap_ev | (wrap_flag_o & ~flag_clr_i);
            ch1_flag_o  <= ch1_hit | (ch1_flag_o & ~flag_clr_i);
            ch2_flag_o  <= ch2_hit | (ch2_flag_o & ~flag_clr_i);
        end
    end

    // Vector word, priority channel 1 then 2 then wrap
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            timer_vector_word_o <= `VEC_NONE;
        end
        // Full control write clears the vector
        else if (ctl_wr_i)
        begin
            timer_vector_word_o <= `VEC_NONE;
        end
        else if (ch1_hit || ch1_flag_o)
        begin
            timer_vector_word_o <= `VEC_CH1;
        end
        else if (ch2_hit || ch2_flag_o)
        begin
            timer_vector_word_o <= `VEC_CH2;
        end
        else if (wrap_ev || wrap_flag_o)
        begin
            timer_vector_word_o <= `VEC_WRAP;
        end
        else
        begin
            timer_vector_word_o <= `VEC_NONE;
        end
    end

endmodule

`default_nettype wire

/* File: pkg/interval_timer_map.vh */
// Constants for the interval timer with compare channels.
// Assumes inclusion by bare name from the design files.
`ifndef INTERVAL_TIMER_MAP_VH
`define INTERVAL_TIMER_MAP_VH

// Clock source select codes
`define SRC_EXT_CLK      2'h0
`define SRC_AUX_CLK      2'h1
`define SRC_SUB_CLK      2'h2
`define SRC_INV_EXT_CLK  2'h3

// Count modes
`define MODE_STOP        2'h0
`define MODE_UP          2'h1
`define MODE_CONT        2'h2
`define MODE_UPDOWN      2'h3

// Input divider codes
`define DIV_1            2'h0
`define DIV_2            2'h1
`define DIV_4            2'h2
`define DIV_8            2'h3

// Control word fields
`define CTL_SRC_LSB      8
`define CTL_DIV_LSB      6
`define CTL_MODE_LSB     4
`define CTL_CLR_BIT      2
`define CTL_RESET_VAL    16'h0000

// Vector word codes
`define VEC_NONE         4'h0
`define VEC_CH1          4'h2
`define VEC_CH2          4'h4
`define VEC_WRAP         4'hA

`define COUNT_ZERO       16'h0000
`define COUNT_ONE        16'h0001
`define DIV_CNT_ZERO     3'h0

`endif

/* File: design/count_edge_sync.v */
// Edge synchroniser for the selected count clock.
// Assumes the count clock is a slow level sampled by clk_sys_i.
`timescale 1ns/1ps
`default_nettype none

module count_edge_sync
(
    input  wire clk_sys_i,   // System clock
    input  wire rst_n_i,     // Sync reset, active low
    input  wire level_i,     // Raw count clock level
    output reg  rise_o       // One-cycle rising edge pulse
);

    reg sync1_q;
    reg sync2_q;
    reg prev_q;

    // Two-flop synchroniser, edge taken only after the second stage
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
            rise_o  <= 1'b0;
        end
        else
        begin
            sync1_q <= level_i;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            rise_o  <= sync2_q & ~prev_q;
        end
    end

endmodule

`default_nettype wire

/* File: tb/interval_timer_compare_monitor.sv */
// Port checker for the interval timer, bound onto its top module.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
// ****************
// Port checker
// ****************
module timer_chk #(parameter W = 16)
(
    input wire         clk_sys_i,            // Clock
    input wire         rst_n_i,              // Reset
    input wire         ctl_wr_i,             // Control write
    input wire [W-1:0] ctl_wdata_i,          // Control data
    input wire [W-1:0] running_count_o,      // Count
    input wire [W-1:0] timer_control_word_o, // Control
    input wire [3:0]   timer_vector_word_o,  // Vector
    input wire         wrap_flag_o,          // Wrap flag
    input wire         ch1_flag_o            // Compare flag
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // Clear bit is not stored, so only the fields are compared
    AST_CTL_RB: assert property (
        ctl_wr_i |=> timer_control_word_o[9:4] == $past(ctl_wdata_i[9:4]))
        else $error("control readback wrong");
    AST_VEC_CLR: assert property (ctl_wr_i |=> timer_vector_word_o == 4'h0)
        else $error("vector not cleared");
    AST_CLR_ZERO: assert property (ctl_wr_i && ctl_wdata_i[2] |=> ~|running_count_o)
        else $error("clear left count");
    // Reset itself is the cause here, so it must not disable the check
    AST_RST_ZERO: assert property (@(posedge clk_sys_i) disable iff (1'b0)
        !rst_n_i |=> ~|running_count_o && !wrap_flag_o && ~|timer_control_word_o)
        else $error("reset left state");
    AST_STEP: assert property ($changed(running_count_o) |->
        running_count_o == $past(running_count_o) + 1'b1 || ~|running_count_o)
        else $error("count jumped");
    AST_WRAP: assert property ($rose(wrap_flag_o) && $past(timer_control_word_o[5:4]) == 2'h1
        |-> ~|running_count_o && |$past(running_count_o))
        else $error("wrap without period step");
    AST_CH1_STEP: assert property ($rose(ch1_flag_o) |-> $changed(running_count_o))
        else $error("compare flag without step");
    AST_CTL_HOLD: assert property (!ctl_wr_i |=> $stable(timer_control_word_o))
        else $error("control changed unwritten");
    cover property ($rose(wrap_flag_o));
    cover property ($rose(ch1_flag_o));
    cover property (ctl_wr_i && ctl_wdata_i[2]);
endmodule
bind interval_timer_compare timer_chk #(.W(W)) i_timer_chk (.*);
`default_nettype wire

/* File: tb/tb_interval_timer_compare.sv */
// Self-checking bench for the interval timer with compare channels.
// Assumes the timer alone; count clocks are driven here as slow levels.
`timescale 1ns/1ps
`default_nettype none
module tb_interval_timer_compare;
    // ********************
    // Stimulus and model
    // ********************
    logic clk_sys_i = 1'h0, rst_n_i = 1'h0, ctl_wr_i = 1'h0, flag_clr_i = 1'h0;
    logic external_count_clock_i = 1'h0, aux_clock_i = 1'h0, subsystem_clock_i = 1'h0;
    logic period_wr_i = 1'h0, ch1_wr_i = 1'h0, ch2_wr_i = 1'h0, up, run = 1'h0;
    logic ch1_cmp_mode_i = 1'h1, ch2_cmp_mode_i = 1'h0, w = 1'h0, f = 1'h0, f2 = 1'h0;
    logic [15:0] ctl_wdata_i = 16'h0000, period_wdata_i = 16'h0000, ch1_wdata_i = 16'h0000;
    logic [15:0] ch2_wdata_i = 16'h0000, cnt = 16'h0000, per, c1, c2, prev;
    wire [15:0] running_count_o, timer_control_word_o;
    wire [3:0] timer_vector_word_o;
    wire wrap_flag_o, ch1_flag_o, ch2_flag_o;
    wire [18:0] seen = {running_count_o, wrap_flag_o, ch1_flag_o, ch2_flag_o};
    logic [31:0] r;
    logic [18:0] q[$];
    int dv = 0, nd = 1, n_errors = 0, n_checks = 0, seed = 32'h13d5_4e2c;
    interval_timer_compare i_interval_timer_compare (.*);
    always #10 clk_sys_i = ~clk_sys_i;
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        n_checks++;
        if (got !== want)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic stop_test;
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Period, compare and flag-clear strobes share one data word
    task automatic put(input logic [3:0] m, input logic [15:0] v);
        {period_wr_i, ch1_wr_i, ch2_wr_i, flag_clr_i} <= m;
        {period_wdata_i, ch1_wdata_i, ch2_wdata_i} <= {3{v}};
        if (m[3]) per = v;
        if (m[2]) c1 = v;
        if (m[1]) c2 = v;
        if (m[0]) {w, f, f2} = 3'h0;
        @(posedge clk_sys_i);
        {period_wr_i, ch1_wr_i, ch2_wr_i, flag_clr_i} <= 4'h0;
        @(posedge clk_sys_i);
    endtask
    task automatic cfg(input logic [15:0] v);
        ctl_wr_i <= 1'h1;
        ctl_wdata_i <= v;
        if (v[2] && cnt != 16'h0000) q.push_back({16'h0000, w, f, f2});
        if (v[2]) {cnt, dv} = 0;
        run = v[5:4] != 2'h0;
        up = v[5:4] == 2'h1;
        nd = 1 << v[7:6];
        @(posedge clk_sys_i);
        ctl_wr_i <= 1'h0;
        #1;
        check(timer_control_word_o, v & 16'hfffb);
        check(timer_vector_word_o, 4'h0);
        @(posedge clk_sys_i);
    endtask
    // One period of the chosen source; the others toggle at random only while it is high
    task automatic tick(input logic [1:0] s);
        dv += run;
        if (run && dv == nd)
        begin
            dv = 0;
            w = w | (up && cnt == per);
            cnt = (up && cnt == per) ? 16'h0000 : cnt + 16'h0001;
            f = f | (ch1_cmp_mode_i && cnt == c1);
            f2 = f2 | (ch2_cmp_mode_i && cnt == c2);
            q.push_back({cnt, w, f, f2});
        end
        for (int lv = 1; lv >= 0; lv--)
        begin
            r = lv ? $random(seed) : 32'h0000_0000;
            aux_clock_i <= (s == 2'h1) ? lv[0] : r[0];
            subsystem_clock_i <= (s == 2'h2) ? lv[0] : r[1];
            external_count_clock_i <= (s[0] == s[1]) ? lv[0] ^ s[0] : r[2];
            repeat (4) @(posedge clk_sys_i);
        end
    endtask
    // Each count change is matched against the oldest note
    always @(posedge clk_sys_i)
    begin
        if (rst_n_i && running_count_o !== prev)
            check(seen, q.size() ? q.pop_front() : 19'h7_ffff);
        prev = running_count_o;
    end
    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'h1;
        // Every source and divider in up mode
        for (int s = 0; s < 4; s++)
        begin
            r = $random(seed);
            if (s == 3) external_count_clock_i <= 1'h1;
            ch2_cmp_mode_i <= r[8];
            ch1_cmp_mode_i <= r[9];
            put(4'b1011, {14'h0000, r[1:0]} + 16'h0002);
            put(4'b0100, 16'h0001 + r[5:2] % per);
            cfg({6'h00, s[1:0], s[1:0], 6'h14});
            repeat (8 * per + 10) tick(s[1:0]);
        end
        // Vector shows channel 1, then channel 2, then wrap
        check(timer_vector_word_o, f ? 4'h2 : f2 ? 4'h4 : w ? 4'hA : 4'h0);
        ch1_cmp_mode_i <= 1'h1;
        // Stop at period, clear, restart up
        cfg(16'h0314);
        repeat (per) tick(2'h3);
        cfg(16'h0300);
        repeat (2) tick(2'h3);
        cfg(16'h0304);
        put(4'b0001, 16'h0000);
        cfg(16'h0310);
        repeat (per + 2) tick(2'h3);
        put(4'b0100, 16'h0001);
        cfg(16'h0124);
        repeat (6)
        begin
            tick(2'h1);
            put(4'b0101, c1 + 16'h0001);
        end
        cfg(16'h0234);
        repeat (3) tick(2'h2);
        rst_n_i <= 1'h0;
        {cnt, w, f, f2, run, dv} = 0;
        put(4'b0110, 16'h0005);
        // Writes made while in reset are lost; compare values restart at zero
        {per, c1, c2} = 0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'h1;
        @(posedge clk_sys_i);
        #1;
        check(running_count_o, 16'h0000);
        check(timer_control_word_o, 16'h0000);
        check(timer_vector_word_o, 4'h0);
        @(posedge clk_sys_i);
        put(4'b0100, 16'h0005);
        cfg(16'h0234);
        repeat (7) tick(2'h2);
        repeat (8) @(posedge clk_sys_i);
        check(timer_vector_word_o, f ? 4'h2 : f2 ? 4'h4 : w ? 4'hA : 4'h0);
        check(q.size(), 0);
        stop_test;
    end
    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        stop_test;
    end
endmodule
`default_nettype wire
